// File: inc/wait_bridge_pkg.sv
`default_nettype none
package wait_bridge_pkg;

    // =====================================================================
    // access targets on the peripheral side
    typedef enum logic [2:0] {
        TGT_PLAIN       = 3'h0,
        TGT_SER_A_RX    = 3'h1,
        TGT_SER_B_RX    = 3'h2,
        TGT_CONV_MODE   = 3'h3,
        TGT_CONV_CHAN   = 3'h4,
        TGT_CONV_PORT   = 3'h5,
        TGT_CONV_RESULT = 3'h6
    } target_t;

    // =====================================================================
    // conversion clock choice, as a divide of the peripheral clock
    typedef enum logic [2:0] {
        CONV_DIV2  = 3'h0,
        CONV_DIV3  = 3'h1,
        CONV_DIV4  = 3'h2,
        CONV_DIV6  = 3'h3,
        CONV_DIV8  = 3'h4,
        CONV_DIV12 = 3'h5
    } conv_div_t;

    // =====================================================================
    // bridge sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_XFER = 2'h2
    } bridge_state_t;

    localparam int         DATA_W          = 8;
    localparam int         WAIT_W          = 5;
    localparam int         CPU_SHIFT_W     = 3;
    // fcpu = fprs >> shift; slowest cpu clock is fprs/16
    localparam logic [2:0] CPU_SHIFT_MAX   = 3'h4;
    localparam logic [4:0] SERIAL_WAITS    = 5'h01;
    localparam logic [4:0] RESULT_MIN_WAIT = 5'h02;
    localparam logic [4:0] WAIT_OFFSET     = 5'h01;
    localparam logic [4:0] WAIT_NONE       = 5'h00;
    localparam logic [4:0] CNT_LAST        = 5'h01;

endpackage
`default_nettype wire

// File: logic/conv_wait_calc.sv
`timescale 1ns/1ps
`default_nettype none
module conv_wait_calc (
    input  wire wait_bridge_pkg::target_t   target_i,
    input  wire logic                       we_i,
    input  wire wait_bridge_pkg::conv_div_t conv_sel_i,
    input  wire logic [2:0]                 cpu_shift_i,
    output logic [4:0]                      waits_o
);
    import wait_bridge_pkg::*;

    // =====================================================================
    // divider decode; anything past /12 falls back to the slowest choice
    function automatic logic [4:0] conv_divisor(input conv_div_t sel);
        case (sel)
            CONV_DIV2: conv_divisor = 5'h02;
            CONV_DIV3: conv_divisor = 5'h03;
            CONV_DIV4: conv_divisor = 5'h04;
            CONV_DIV6: conv_divisor = 5'h06;
            CONV_DIV8: conv_divisor = 5'h08;
            default:   conv_divisor = 5'h0C;
        endcase
    endfunction

    wire logic [2:0] shift;
    wire logic [5:0] twice_ratio;
    wire logic [5:0] whole;
    wire logic [5:0] frac;
    wire logic [5:0] half;
    wire logic       round_up;
    wire logic [4:0] conv_waits;
    wire logic       is_conv;
    wire logic       is_serial;

    // 2*fcpu/fad with both clocks from one source: 2*div >> shift
    assign shift       = (cpu_shift_i > CPU_SHIFT_MAX) ? CPU_SHIFT_MAX
                                                       : cpu_shift_i;
    assign twice_ratio = {conv_divisor(conv_sel_i), 1'b0};
    assign whole       = twice_ratio >> shift;
    assign frac        = twice_ratio & ((6'h01 << shift) - 6'h01);
    assign half        = (6'h01 << shift) >> 1;
    // a fraction of exactly one half is dropped, only above it rounds up
    assign round_up    = (shift != 3'h0) && (frac > half);
    assign conv_waits  = whole[4:0] + {4'h0, round_up} + WAIT_OFFSET;

    assign is_serial = !we_i && ((target_i == TGT_SER_A_RX) ||
                                 (target_i == TGT_SER_B_RX));
    assign is_conv   = (we_i && ((target_i == TGT_CONV_MODE) ||
                                 (target_i == TGT_CONV_CHAN) ||
                                 (target_i == TGT_CONV_PORT))) ||
                       (target_i == TGT_CONV_RESULT);

    // result reads never go below their two-cycle floor
    assign waits_o =
        is_serial ? SERIAL_WAITS :
        (!is_conv) ? WAIT_NONE :
        ((target_i == TGT_CONV_RESULT) && !we_i &&
         (conv_waits < RESULT_MIN_WAIT)) ? RESULT_MIN_WAIT :
        conv_waits;
endmodule
`default_nettype wire

// File: logic/stall_counter.sv
`timescale 1ns/1ps
`default_nettype none
module stall_counter (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       load_i,
    input  wire logic [4:0] value_i,
    input  wire logic       run_i,
    output logic            last_o
);
    import wait_bridge_pkg::*;

    logic [4:0] count;

    // =====================================================================
    // down counter; it holds while the peripheral clock is stopped
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= WAIT_NONE;
        end else if (load_i) begin
            count <= value_i;
        end else if (run_i && (count != WAIT_NONE)) begin
            count <= count - CNT_LAST;
        end
    end

    assign last_o = run_i && (count == CNT_LAST);
endmodule
`default_nettype wire

// File: logic/periph_wait_bridge.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Processor side and peripheral side are separate buses, both clocked by clk_i from one source.
// - Peripheral access is repeated; data is taken only when the wait ends.
// - Stall output holds the processor for the computed wait count, plus any cycles the peripheral clock is stopped.
// - Converter setup writes: 1..5 waits at /2, 1..7 at /3.
// - Converter accesses: 1..9 waits at /4, 2..13 at /6.
// - Result reads: 2..17 waits at /8, 2..25 at /12.
// - Converter waits are two times cpu-to-conversion clock ratio plus one.
// - Fractions up to one half drop; larger fractions round up.
// - Conversion clock is one of /2 through /12 of the peripheral clock.
// - Wait figures assume cpu and peripheral clocks from one source.
module periph_wait_bridge (
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    // processor side
    input  wire logic                       cpu_req_i,
    input  wire logic                       cpu_we_i,
    input  wire wait_bridge_pkg::target_t   cpu_target_i,
    input  wire logic [7:0]                 cpu_wdata_i,
    output logic                            cpu_stall_o,
    output logic                            cpu_done_o,
    output logic [7:0]                      cpu_rdata_o,
    // clock setup
    input  wire wait_bridge_pkg::conv_div_t conv_sel_i,
    input  wire logic [2:0]                 cpu_shift_i,
    input  wire logic                       prs_run_i,
    // peripheral side
    output logic                            per_req_o,
    output logic                            per_we_o,
    output wait_bridge_pkg::target_t        per_target_o,
    output logic [7:0]                      per_wdata_o,
    input  wire logic [7:0]                 per_rdata_i
);
    import wait_bridge_pkg::*;

    bridge_state_t state;
    bridge_state_t next_state;
    logic [4:0]    wait_len;
    wire logic [4:0] calc_waits;
    wire logic       cnt_last;
    wire logic       accept;
    wire logic       finish;
    wire logic       load_cnt;

    // =====================================================================
    // wait figure for the access now offered
    conv_wait_calc u_calc (
        .target_i    (cpu_target_i),
        .we_i        (cpu_we_i),
        .conv_sel_i  (conv_sel_i),
        .cpu_shift_i (cpu_shift_i),
        .waits_o     (calc_waits)
    );

    // =====================================================================
    // stall timing
    stall_counter u_cnt (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .load_i  (load_cnt),
        .value_i (calc_waits),
        .run_i   (prs_run_i),
        .last_o  (cnt_last)
    );

    // =====================================================================
    // sequencing; requests outside idle are ignored, the cpu is stalled
    assign accept   = (state == ST_IDLE) && cpu_req_i;
    assign load_cnt = accept;
    assign finish   = (state == ST_XFER);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cpu_req_i) begin
                    next_state = (calc_waits == WAIT_NONE) ? ST_XFER
                                                           : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_last) begin
                    next_state = ST_XFER;
                end
            end
            ST_XFER: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // =====================================================================
    // stall line: high from accept until the counter runs out
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_stall_o <= 1'b0;
        end else if (accept) begin
            cpu_stall_o <= (calc_waits != WAIT_NONE);
        end else if (cnt_last) begin
            cpu_stall_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_len <= WAIT_NONE;
        end else if (accept) begin
            wait_len <= calc_waits;
        end
    end

    // =====================================================================
    // peripheral bus: request held across the whole wait so the far side
    // is resampled each cycle; the far side settles during the wait, so only the last
    // sample is known to be settled
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            per_req_o    <= 1'b0;
            per_we_o     <= 1'b0;
            per_target_o <= TGT_PLAIN;
            per_wdata_o  <= 8'h00;
        end else if (accept) begin
            per_req_o    <= 1'b1;
            per_we_o     <= cpu_we_i;
            per_target_o <= cpu_target_i;
            per_wdata_o  <= cpu_wdata_i;
        end else if (finish) begin
            per_req_o    <= 1'b0;
            per_we_o     <= 1'b0;
        end
    end

    // =====================================================================
    // completion and read data; earlier samples are never passed on
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_done_o  <= 1'b0;
            cpu_rdata_o <= 8'h00;
        end else begin
            cpu_done_o <= finish;
            if (finish && !per_we_o) begin
                cpu_rdata_o <= per_rdata_i;
            end
        end
    end

    // =====================================================================
    // checks
    logic [4:0] stall_run;

    // counts the cycles the stall has really been paid for
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stall_run <= WAIT_NONE;
        end else if (accept) begin
            stall_run <= WAIT_NONE;
        end else if (cpu_stall_o && prs_run_i) begin
            stall_run <= stall_run + CNT_LAST;
        end
    end

    a_stall_len_exact: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(cpu_stall_o) |-> (stall_run == wait_len))
        else $error("stall length differs from wait count");

    a_serial_one_wait: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && !cpu_we_i && ((cpu_target_i == TGT_SER_A_RX) ||
         (cpu_target_i == TGT_SER_B_RX))) ##1 prs_run_i
        |-> cpu_stall_o ##1 !cpu_stall_o ##1 cpu_done_o)
        else $error("serial buffer read not one wait");

    a_setup_div2_range: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && cpu_we_i && (conv_sel_i == CONV_DIV2) &&
         (cpu_target_i == TGT_CONV_MODE))
        |-> (calc_waits >= 5'h01) && (calc_waits <= 5'h05))
        else $error("setup write wait out of range at div2");

    a_conv_div6_range: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && cpu_we_i && (conv_sel_i == CONV_DIV6) &&
         (cpu_target_i == TGT_CONV_CHAN))
        |-> (calc_waits >= 5'h02) && (calc_waits <= 5'h0D))
        else $error("converter wait out of range at div6");

    a_result_div12_range: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && !cpu_we_i && (conv_sel_i == CONV_DIV12) &&
         (cpu_target_i == TGT_CONV_RESULT))
        |-> (calc_waits >= 5'h02) && (calc_waits <= 5'h19))
        else $error("result read wait out of range at div12");

    a_formula_fast_cpu: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && (cpu_shift_i == 3'h0) && (conv_sel_i == CONV_DIV4) &&
         (cpu_target_i == TGT_CONV_RESULT))
        |-> (calc_waits == 5'h09))
        else $error("wait formula wrong at full cpu speed");

    a_round_half_down: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && (cpu_shift_i == 3'h2) && (conv_sel_i == CONV_DIV3) &&
         cpu_we_i && (cpu_target_i == TGT_CONV_PORT))
        |-> (calc_waits == 5'h02))
        else $error("half fraction was not dropped");

    a_round_up_frac: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && (cpu_shift_i == 3'h3) && (conv_sel_i == CONV_DIV3) &&
         cpu_we_i && (cpu_target_i == TGT_CONV_PORT))
        |-> (calc_waits == 5'h02))
        else $error("large fraction was not rounded up");

    a_data_last_sample: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (finish && !per_we_o) |=> (cpu_rdata_o == $past(per_rdata_i)))
        else $error("read data not taken at end of wait");

    a_hold_when_stopped: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (cpu_stall_o && !prs_run_i) |=> cpu_stall_o)
        else $error("stall released with peripheral clock stopped");

    a_plain_no_stall: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && (cpu_target_i == TGT_PLAIN))
        |=> !cpu_stall_o ##1 cpu_done_o)
        else $error("plain access was stalled");

    // the far side keeps seeing the request for the whole stall
    a_req_over_stall: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        cpu_stall_o |-> per_req_o)
        else $error("peripheral request dropped during stall");

    a_req_off_done: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        cpu_done_o |-> !per_req_o)
        else $error("peripheral request still up at completion");

    a_done_one_cycle: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        cpu_done_o |=> !cpu_done_o)
        else $error("completion pulse longer than one cycle");

    a_setup_div3_range: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && cpu_we_i && (conv_sel_i == CONV_DIV3) &&
         (cpu_target_i == TGT_CONV_PORT))
        |-> (calc_waits >= 5'h01) && (calc_waits <= 5'h07))
        else $error("setup write wait out of range at div3");

    a_conv_div4_range: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && cpu_we_i && (conv_sel_i == CONV_DIV4) &&
         (cpu_target_i == TGT_CONV_MODE))
        |-> (calc_waits >= 5'h01) && (calc_waits <= 5'h09))
        else $error("converter wait out of range at div4");

    a_result_div8_range: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && !cpu_we_i && (conv_sel_i == CONV_DIV8) &&
         (cpu_target_i == TGT_CONV_RESULT))
        |-> (calc_waits >= 5'h02) && (calc_waits <= 5'h11))
        else $error("result read wait out of range at div8");

    // a slow cpu must still pay the two-cycle floor on result reads
    a_result_floor: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && !cpu_we_i && (cpu_target_i == TGT_CONV_RESULT))
        |-> (calc_waits >= RESULT_MIN_WAIT))
        else $error("result read below its wait floor");

    a_bad_sel_slowest: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (accept && cpu_we_i && (conv_sel_i > CONV_DIV12) &&
         (cpu_shift_i == 3'h0) && (cpu_target_i == TGT_CONV_PORT))
        |-> (calc_waits == 5'h19))
        else $error("unused divider code not treated as slowest");

    c_serial_read: cover property (
        @(posedge clk_i) disable iff (!rst_b_i)
        accept && (cpu_target_i == TGT_SER_B_RX) && !cpu_we_i);

    c_longest_wait: cover property (
        @(posedge clk_i) disable iff (!rst_b_i)
        accept && (calc_waits == 5'h19));

    c_paused_stall: cover property (
        @(posedge clk_i) disable iff (!rst_b_i)
        cpu_stall_o && !prs_run_i ##1 cpu_stall_o && prs_run_i);

    c_round_up_write: cover property (
        @(posedge clk_i) disable iff (!rst_b_i)
        accept && cpu_we_i && (cpu_shift_i == 3'h3) &&
        (conv_sel_i == CONV_DIV3));

    c_back_to_back: cover property (
        @(posedge clk_i) disable iff (!rst_b_i)
        cpu_done_o ##1 accept);
endmodule
`default_nettype wire

// File: dv/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    input  wire logic                     clk_i,
    input  wire logic                     rst_b_i,
    input  wire logic                     per_req_i,
    input  wire logic                     per_we_i,
    input  wire wait_bridge_pkg::target_t per_target_i,
    input  wire logic [7:0]               per_wdata_i,
    output logic [7:0]                    per_rdata_o
);
    import wait_bridge_pkg::*;

    logic [7:0] mem [0:7];
    logic [7:0] last;

    // =====================================================================
    // register contents; a write lands while the request stands
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int k = 0; k < 8; k++) begin
                mem[k] <= 8'hA0 | 8'(k);
            end
            last <= 8'h00;
        end else begin
            if (per_req_i && per_we_i) begin
                mem[per_target_i] <= per_wdata_i;
            end
            last <= per_rdata_o;
        end
    end

    // released bus toggles, so stale data can never pass for a reply
    assign per_rdata_o = per_req_i ? mem[per_target_i] : ~last;
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wait_bridge_pkg::*;

    logic       clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic       cpu_req_i = 1'b0;
    logic       cpu_we_i = 1'b0;
    target_t    cpu_target_i = TGT_PLAIN;
    logic [7:0] cpu_wdata_i = 8'h00;
    conv_div_t  conv_sel_i = CONV_DIV2;
    logic [2:0] cpu_shift_i = 3'h0;
    logic       prs_run_i = 1'b1;
    logic       cpu_stall_o;
    logic       cpu_done_o;
    logic [7:0] cpu_rdata_o;
    logic       per_req_o;
    logic       per_we_o;
    target_t    per_target_o;
    logic [7:0] per_wdata_o;
    logic [7:0] per_rdata_i;
    int         errors = 0;
    int         compares = 0;
    int         cycles = 0;
    int         div_tab [0:5] = '{2, 3, 4, 6, 8, 12};
    logic [7:0] shadow [0:7] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3,
                                 8'hA4, 8'hA5, 8'hA6, 8'hA7};

    periph_wait_bridge periph_wait_bridge_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .cpu_req_i(cpu_req_i),
        .cpu_we_i(cpu_we_i), .cpu_target_i(cpu_target_i),
        .cpu_wdata_i(cpu_wdata_i), .cpu_stall_o(cpu_stall_o),
        .cpu_done_o(cpu_done_o), .cpu_rdata_o(cpu_rdata_o),
        .conv_sel_i(conv_sel_i), .cpu_shift_i(cpu_shift_i),
        .prs_run_i(prs_run_i), .per_req_o(per_req_o), .per_we_o(per_we_o),
        .per_target_o(per_target_o), .per_wdata_o(per_wdata_o),
        .per_rdata_i(per_rdata_i)
    );

    periph_model periph_model_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .per_req_i(per_req_o),
        .per_we_i(per_we_o), .per_target_i(per_target_o),
        .per_wdata_i(per_wdata_o), .per_rdata_o(per_rdata_i)
    );

    // =====================================================================
    // clock and hang guard; ceiling is far above the expected run length
    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("mismatch at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %0h expected %0h",
                     $time, what, seen, exp);
        end
    endtask

    // =====================================================================
    // expected stall, cpu clock taken as the peripheral clock shifted down
    function automatic int exp_waits(input int t, input int w,
                                     input int sel, input int sh);
        int num;
        int den;
        int q;
        num = 2 * div_tab[sel > 5 ? 5 : sel];
        den = 1 << (sh > 4 ? 4 : sh);
        q = num / den;
        if (2 * (num % den) > den) q++;
        q = q + 1;
        if (t == 1 || t == 2) return w ? 0 : 1;
        if (t == 6) return (w == 0 && q < 2) ? 2 : q;
        if (t >= 3 && t <= 5 && w != 0) return q;
        return 0;
    endfunction

    // one access; pause holds the peripheral clock off for that many cycles
    task automatic access(input int t, input int w, input int sel,
                          input int sh, input int pause);
        int n;
        int st;
        int nexp;
        logic [7:0] wd;
        nexp = exp_waits(t, w, sel, sh);
        wd = 8'(8'h3C + t * 17 + sel * 5 + sh);
        @(posedge clk_i);
        cpu_req_i <= 1'b1;
        cpu_we_i <= w[0];
        cpu_target_i <= target_t'(t[2:0]);
        cpu_wdata_i <= wd;
        conv_sel_i <= conv_div_t'(sel[2:0]);
        cpu_shift_i <= sh[2:0];
        @(posedge clk_i);
        cpu_req_i <= 1'b0;
        if (pause > 0) prs_run_i <= 1'b0;
        n = 0;
        st = 0;
        #1;
        check(per_req_o, 1, "peripheral request");
        check(per_target_o, t, "peripheral target");
        check(per_we_o, w, "peripheral direction");
        if (w != 0) check(per_wdata_o, wd, "peripheral data");
        while (cpu_done_o !== 1'b1 && n < 60) begin
            if (cpu_stall_o === 1'b1) st++;
            @(posedge clk_i);
            n++;
            if (n == pause) prs_run_i <= 1'b1;
            #1;
        end
        check(n, nexp + 1 + pause, "completion time");
        check(st, nexp == 0 ? 0 : nexp + pause, "stall cycles");
        check(per_req_o, 0, "request dropped at done");
        if (w == 0) check(cpu_rdata_o, shadow[t], "read data");
        else shadow[t] = wd;
    endtask

    // =====================================================================
    // scenarios
    task automatic t_reset();
        check(cpu_stall_o, 0, "stall after reset");
        check(cpu_done_o, 0, "done after reset");
        check(per_req_o, 0, "request after reset");
        $display("test reset done");
    endtask

    task automatic t_serial();
        access(1, 0, 0, 0, 0);
        access(2, 0, 5, 3, 0);
        access(2, 0, 3, 7, 0);
        access(1, 1, 0, 0, 0);
        access(1, 0, 0, 0, 0);
        $display("test serial done");
    endtask

    task automatic t_conv_setup();
        for (int t = 3; t <= 5; t++) begin
            for (int s = 0; s <= 5; s++) begin
                access(t, 1, s, 0, 0);
            end
            access(t, 0, 5, 0, 0);
        end
        $display("test converter setup done");
    endtask

    task automatic t_result();
        for (int sh = 0; sh <= 4; sh++) begin
            access(6, 0, 0, sh, 0);
            access(6, 0, 5, sh, 0);
        end
        access(6, 0, 1, 2, 0);
        access(6, 0, 1, 3, 0);
        access(6, 0, 6, 7, 0);
        access(6, 1, 0, 3, 0);
        access(6, 0, 2, 1, 0);
        // floor-free cases, so rounding and decode faults show up
        access(6, 0, 4, 0, 0);
        access(6, 0, 2, 0, 0);
        access(5, 1, 1, 2, 0);
        access(5, 1, 1, 3, 0);
        access(5, 1, 7, 0, 0);
        access(4, 1, 5, 5, 0);
        $display("test result register done");
    endtask

    task automatic t_plain_pause();
        access(0, 1, 0, 0, 0);
        access(0, 0, 0, 0, 0);
        access(6, 0, 0, 0, 3);
        access(4, 1, 3, 1, 1);
        access(2, 0, 0, 0, 2);
        $display("test plain and pause done");
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        #1;
        t_reset();
        t_serial();
        t_conv_setup();
        t_result();
        t_plain_pause();
        end_of_test();
    end
endmodule
`default_nettype wire
